// file: src/phy_vendor_config_low_bits.sv
// Low six bits of the vendor configuration register, reached over the serial
// management pins, plus the indicator, sleep, machine reset and loopout logic.
// Assumes the management clock and data arrive as raw pins and that line status
// comes from datapath logic on core_clk_i.
`timescale 1ns/100ps

// What this block does
// - Link mode 0: LED shows link only
// - Link mode 1: lit on link, flashes on traffic
// - Duplex mode 1: LED shows 10 Mb polarity
// - Duplex mode 0: LED shows full duplex
// - Writing machine reset resets all state machines
// - Machine reset bit clears itself when done
// - Preamble needed unless suppression bit set
// - Sleep bit darkens both indicators; loopout keeps running
// - Wake keeps config, restarts state machines
// - Loopout sends received data back out
module phy_vendor_config_low_bits #(
   parameter int BLINK_HALF_CYCLES = phy_cfg_pkg::BLINK_HALF_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic mdc_i,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe_o,
   input wire logic [4:0] phy_addr_i,
   input wire phy_cfg_pkg::line_status_t line_status_i,
   input wire logic [phy_cfg_pkg::SYM_W-1:0] rx_sym_i,
   input wire logic [phy_cfg_pkg::SYM_W-1:0] tx_sym_i,
   output logic [phy_cfg_pkg::SYM_W-1:0] line_tx_sym_o,
   output logic link_led_out_o,
   output logic duplex_led_out_o,
   output logic sm_reset_o,
   output logic sleep_o
);

   localparam logic [4:0] SM_LOAD = 5'(phy_cfg_pkg::SM_RESET_CYCLES);

   // Pin synchronisers
   logic mdc_s1_r, mdc_s2_r, mdc_s3_r;
   logic mdio_s1_r, mdio_s2_r;
   logic [4:0] addr_s1_r, addr_s2_r, addr_r;
   logic [1:0] strap_cnt_r;

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mdc_s1_r <= 1'b0;
         mdc_s2_r <= 1'b0;
         mdc_s3_r <= 1'b0;
         mdio_s1_r <= 1'b1;
         mdio_s2_r <= 1'b1;
      end else begin
         mdc_s1_r <= mdc_i;
         mdc_s2_r <= mdc_s1_r;
         mdc_s3_r <= mdc_s2_r;
         mdio_s1_r <= mdio_i;
         mdio_s2_r <= mdio_s1_r;
      end
   end

   // Strapped PHY address; the first two edges see stale sync stages, the third catches it
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         addr_s1_r <= 5'h00;
         addr_s2_r <= 5'h00;
         addr_r <= 5'h00;
         strap_cnt_r <= 2'h0;
      end else begin
         addr_s1_r <= phy_addr_i;
         addr_s2_r <= addr_s1_r;
         if (strap_cnt_r != phy_cfg_pkg::STRAP_SETTLE + 2'h1) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
            addr_r <= addr_s2_r;
         end
      end
   end

   wire mdc_rise_w = mdc_s2_r && !mdc_s3_r;
   wire mdio_bit_w = mdio_s2_r;

   // Frame receiver state
   phy_cfg_pkg::mgmt_state_t state_r, state_nxt;
   logic [4:0] cnt_r, cnt_nxt;
   logic [5:0] pre_cnt_r;
   logic [15:0] shift_r;
   logic [11:0] hdr_r;
   logic drive_r, out_r;
   phy_cfg_pkg::vendor_cfg_t cfg_r;
   logic [4:0] sm_cnt_r;
   logic sm_reset_r;

   wire pre_full_w = (pre_cnt_r == phy_cfg_pkg::PREAMBLE_BITS);
   wire in_idle_w = (state_r == phy_cfg_pkg::MGMT_IDLE);
   wire in_hdr_w = (state_r == phy_cfg_pkg::MGMT_HDR);
   wire in_ta_w = (state_r == phy_cfg_pkg::MGMT_TA);
   wire in_data_w = (state_r == phy_cfg_pkg::MGMT_DATA);
   wire start_ok_w = pre_full_w || cfg_r.preamble_skip_ctl;

   // Header decode
   wire [1:0] hdr_op_w = hdr_r[11:10];
   wire [4:0] hdr_phy_w = hdr_r[9:5];
   wire [4:0] hdr_reg_w = hdr_r[4:0];
   wire hit_w = (hdr_phy_w == addr_r) && (hdr_reg_w == phy_cfg_pkg::REG_VENDOR_CONFIG);
   wire rd_hit_w = hit_w && (hdr_op_w == phy_cfg_pkg::OP_READ);
   wire wr_hit_w = hit_w && (hdr_op_w == phy_cfg_pkg::OP_WRITE);

   // Read image: upper bits read as zero, reset bit shows the pulse in flight
   wire [15:0] rd_data_w = {10'h000, cfg_r.link_indicator_mode, cfg_r.duplex_indicator_mode,
                            sm_reset_r, cfg_r.preamble_skip_ctl, cfg_r.sleep,
                            cfg_r.far_loop_back};

   // Bit shifting for header, write data and read data
   wire shift_en_w = mdc_rise_w && (in_hdr_w || in_data_w);
   wire ta_first_w = mdc_rise_w && in_ta_w && (cnt_r == 5'h00);
   wire ta_last_w = mdc_rise_w && in_ta_w && (cnt_r == phy_cfg_pkg::TA_LAST);
   wire data_last_w = mdc_rise_w && in_data_w && (cnt_r == phy_cfg_pkg::DATA_LAST);
   wire hdr_last_w = mdc_rise_w && in_hdr_w && (cnt_r == phy_cfg_pkg::HDR_LAST);
   wire tx_start_w = ta_last_w && rd_hit_w;
   wire in_bit_w = drive_r ? 1'b0 : mdio_bit_w;
   wire [15:0] shift_nxt = tx_start_w ? {rd_data_w[14:0], 1'b0} :
                           shift_en_w ? {shift_r[14:0], in_bit_w} : shift_r;

   // Register write decode
   wire [15:0] wr_data_w = {shift_r[14:0], mdio_bit_w};
   wire wr_cfg_w = data_last_w && wr_hit_w;
   wire wr_sleep_w = wr_data_w[phy_cfg_pkg::BIT_SLEEP];
   wire wr_machine_reset_bit_w = wr_cfg_w && wr_data_w[phy_cfg_pkg::BIT_MACHINE_RESET];
   wire wake_w = wr_cfg_w && cfg_r.sleep && !wr_sleep_w;
   wire sm_start_w = wr_machine_reset_bit_w || wake_w;

   // Frame sequencing on management clock rising edges
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      if (mdc_rise_w) begin
         case (state_r)
            phy_cfg_pkg::MGMT_IDLE: begin
               if (!mdio_bit_w && start_ok_w) begin
                  state_nxt = phy_cfg_pkg::MGMT_START;
               end
            end
            phy_cfg_pkg::MGMT_START: begin
               state_nxt = mdio_bit_w ? phy_cfg_pkg::MGMT_HDR : phy_cfg_pkg::MGMT_IDLE;
               cnt_nxt = 5'h00;
            end
            phy_cfg_pkg::MGMT_HDR: begin
               if (cnt_r == phy_cfg_pkg::HDR_LAST) begin
                  state_nxt = phy_cfg_pkg::MGMT_TA;
                  cnt_nxt = 5'h00;
               end else begin
                  cnt_nxt = cnt_r + 5'h01;
               end
            end
            phy_cfg_pkg::MGMT_TA: begin
               if (cnt_r == phy_cfg_pkg::TA_LAST) begin
                  state_nxt = phy_cfg_pkg::MGMT_DATA;
                  cnt_nxt = 5'h00;
               end else begin
                  cnt_nxt = cnt_r + 5'h01;
               end
            end
            phy_cfg_pkg::MGMT_DATA: begin
               if (cnt_r == phy_cfg_pkg::DATA_LAST) begin
                  state_nxt = phy_cfg_pkg::MGMT_IDLE;
               end else begin
                  cnt_nxt = cnt_r + 5'h01;
               end
            end
            default: begin
               state_nxt = phy_cfg_pkg::MGMT_IDLE;
            end
         endcase
      end
   end

   // Frame state and header capture
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_r <= phy_cfg_pkg::MGMT_IDLE;
         cnt_r <= 5'h00;
         shift_r <= 16'h0000;
         hdr_r <= 12'h000;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         shift_r <= shift_nxt;
         if (hdr_last_w) begin
            hdr_r <= {shift_r[10:0], mdio_bit_w};
         end
      end
   end

   // Preamble counter, saturating, cleared by any zero or a frame
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pre_cnt_r <= 6'h00;
      end else if (mdc_rise_w) begin
         if (!in_idle_w || !mdio_bit_w) begin
            pre_cnt_r <= 6'h00;
         end else if (!pre_full_w) begin
            pre_cnt_r <= pre_cnt_r + 6'h01;
         end
      end
   end

   // Read answer: release for first turnaround bit, drive zero, then data MSB first
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         drive_r <= 1'b0;
         out_r <= 1'b1;
      end else if (ta_first_w && rd_hit_w) begin
         drive_r <= 1'b1;
         out_r <= 1'b0;
      end else if (tx_start_w) begin
         out_r <= rd_data_w[15];
      end else if (data_last_w) begin
         drive_r <= 1'b0;
         out_r <= 1'b1;
      end else if (mdc_rise_w && in_data_w && drive_r) begin
         out_r <= shift_r[15];
      end
   end

   // Configuration fields; machine reset and wake leave them untouched
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg_r <= phy_cfg_pkg::vendor_cfg_t'(phy_cfg_pkg::VENDOR_CONFIG_RESET[5:0]);
      end else if (wr_cfg_w) begin
         cfg_r.link_indicator_mode <= wr_data_w[phy_cfg_pkg::BIT_LINK_MODE];
         cfg_r.duplex_indicator_mode <= wr_data_w[phy_cfg_pkg::BIT_DUPLEX_MODE];
         cfg_r.preamble_skip_ctl <= wr_data_w[phy_cfg_pkg::BIT_PREAMBLE_SKIP];
         cfg_r.sleep <= wr_sleep_w;
         cfg_r.far_loop_back <= wr_data_w[phy_cfg_pkg::BIT_FAR_LOOP];
      end
   end

   // Machine reset pulse; a new start reloads, so set wins over the self clear
   wire [4:0] sm_cnt_nxt = sm_start_w ? SM_LOAD :
                           (sm_cnt_r != 5'h00) ? sm_cnt_r - 5'h01 : 5'h00;

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sm_cnt_r <= 5'h00;
         sm_reset_r <= 1'b0;
      end else begin
         sm_cnt_r <= sm_cnt_nxt;
         sm_reset_r <= (sm_cnt_nxt != 5'h00);
      end
   end

   // Indicators, dark while asleep; loopout keeps running while asleep
   logic dark_w;
   logic link_led_r, duplex_led_r;
   logic [phy_cfg_pkg::SYM_W-1:0] tx_sym_r;
   wire link_plain_w = line_status_i.link_good && !cfg_r.sleep;
   wire pol_w = line_status_i.speed_10 && line_status_i.polarity_reversed && !cfg_r.sleep;
   wire fdx_w = line_status_i.full_duplex && !cfg_r.sleep;
   wire link_w = cfg_r.link_indicator_mode ? (link_plain_w && !dark_w) : link_plain_w;
   wire duplex_w = cfg_r.duplex_indicator_mode ? pol_w : fdx_w;

   link_blink #(
      .HALF_CYCLES(BLINK_HALF_CYCLES)
   ) u_blink (
      .core_clk_i(core_clk_i),
      .arst_n_i(arst_n_i),
      .restart_i(sm_reset_r || cfg_r.sleep),
      .activity_i(line_status_i.activity),
      .dark_o(dark_w)
   );

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         link_led_r <= 1'b0;
         duplex_led_r <= 1'b0;
         tx_sym_r <= '0;
      end else begin
         link_led_r <= link_w;
         duplex_led_r <= duplex_w;
         tx_sym_r <= cfg_r.far_loop_back ? rx_sym_i : tx_sym_i;
      end
   end

   assign mdio_o = out_r;
   assign mdio_oe_o = drive_r;
   assign link_led_out_o = link_led_r;
   assign duplex_led_out_o = duplex_led_r;
   assign line_tx_sym_o = tx_sym_r;
   assign sm_reset_o = sm_reset_r;
   assign sleep_o = cfg_r.sleep;

   // Checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);

   logic [5:0] run_r;
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         run_r <= 6'h00;
      end else begin
         run_r <= sm_start_w ? 6'h01 : (sm_reset_r ? run_r + 6'h01 : 6'h00);
      end
   end

   sequence s_reset_held;
      sm_reset_o [*8] ##1 sm_reset_o [*8];
   endsequence

   a_link_only_mode: assert property (
      !cfg_r.link_indicator_mode |=> (link_led_out_o == $past(link_plain_w)))
      else $error("link LED not equal to link status");
   a_link_flash_dark: assert property (
      (cfg_r.link_indicator_mode && dark_w) |=> !link_led_out_o)
      else $error("link LED lit during dark blink phase");
   a_duplex_polarity: assert property (
      cfg_r.duplex_indicator_mode |=> (duplex_led_out_o == $past(pol_w)))
      else $error("duplex LED not showing polarity");
   a_duplex_full: assert property (
      !cfg_r.duplex_indicator_mode |=> (duplex_led_out_o == $past(fdx_w)))
      else $error("duplex LED not showing full duplex");
   a_reset_pulse_len: assert property (
      sm_start_w |=> s_reset_held)
      else $error("machine reset pulse too short");
   a_reset_self_clear: assert property (
      $fell(sm_reset_o) |-> ($past(run_r) == 6'h10))
      else $error("machine reset bit did not clear after its pulse");
   a_preamble_gate: assert property (
      (in_idle_w && state_nxt == phy_cfg_pkg::MGMT_START) |->
      ((pre_cnt_r == phy_cfg_pkg::PREAMBLE_BITS) || cfg_r.preamble_skip_ctl))
      else $error("frame started without preamble");
   a_sleep_follows: assert property (
      wr_cfg_w |=> (sleep_o == $past(wr_sleep_w)))
      else $error("sleep output did not follow write");
   a_wake_restart: assert property (
      $fell(sleep_o) |-> (sm_reset_o && $stable(cfg_r.far_loop_back)))
      else $error("wake did not restart state machines");
   a_loop_path: assert property (
      cfg_r.far_loop_back |=> (line_tx_sym_o == $past(rx_sym_i)))
      else $error("receive data not looped out");

endmodule : phy_vendor_config_low_bits

// file: src/phy_cfg_pkg.sv
// Shared constants and types for the low configuration bits of the PHY.
// Assumes a 125 MHz core clock and a serial management frame of the usual layout.
package phy_cfg_pkg;

   // Clock rate and register location
   localparam int CLK_MHZ = 125;
   localparam logic [4:0] REG_VENDOR_CONFIG = 5'h10;
   localparam logic [15:0] VENDOR_CONFIG_RESET = 16'h0000;

   // Field positions inside vendor_config
   localparam int BIT_FAR_LOOP = 0;
   localparam int BIT_SLEEP = 1;
   localparam int BIT_PREAMBLE_SKIP = 2;
   localparam int BIT_MACHINE_RESET = 3;
   localparam int BIT_DUPLEX_MODE = 4;
   localparam int BIT_LINK_MODE = 5;

   // Management frame layout
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [5:0] PREAMBLE_BITS = 6'h20;
   localparam logic [4:0] HDR_LAST = 5'h0B;
   localparam logic [4:0] TA_LAST = 5'h01;
   localparam logic [4:0] DATA_LAST = 5'h0F;
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   // State machine reset pulse, least time rounded up
   localparam int SM_RESET_NS = 128;
   localparam int SM_RESET_CYCLES = (SM_RESET_NS * CLK_MHZ + 999) / 1000;

   // Half period of the activity blink
   localparam int BLINK_HALF_MS = 50;
   localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * CLK_MHZ * 1000;

   // Line symbol width
   localparam int SYM_W = 5;

   // Writable configuration fields, bit 5 down to bit 0
   typedef struct packed {
      logic link_indicator_mode;
      logic duplex_indicator_mode;
      logic machine_reset_bit;
      logic preamble_skip_ctl;
      logic sleep;
      logic far_loop_back;
   } vendor_cfg_t;

   // Line status from the datapath
   typedef struct packed {
      logic link_good;
      logic activity;
      logic full_duplex;
      logic speed_10;
      logic polarity_reversed;
   } line_status_t;

   // Management frame receiver states
   typedef enum logic [2:0] {
      MGMT_IDLE,
      MGMT_START,
      MGMT_HDR,
      MGMT_TA,
      MGMT_DATA
   } mgmt_state_t;

endpackage : phy_cfg_pkg

// file: src/link_blink.sv
// Activity stretcher and blink timer for the link indicator.
// Assumes activity is a level or pulse from logic on the same clock.
`timescale 1ns/100ps
module link_blink #(
   parameter int HALF_CYCLES = phy_cfg_pkg::BLINK_HALF_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic restart_i,
   input wire logic activity_i,
   output logic dark_o
);

   localparam int CW = $clog2(HALF_CYCLES + 1);
   localparam logic [CW-1:0] HALF_LAST = CW'(HALF_CYCLES - 1);

   logic busy_r;
   logic dark_r;
   logic [CW-1:0] cnt_r;
   wire half_done_w = busy_r && (cnt_r == HALF_LAST);

   // One blink is a dark half then a lit half; bursts shorter than that still blink
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         busy_r <= 1'b0;
         dark_r <= 1'b0;
         cnt_r <= '0;
      end else if (restart_i) begin
         busy_r <= 1'b0;
         dark_r <= 1'b0;
         cnt_r <= '0;
      end else if (!busy_r) begin
         busy_r <= activity_i;
         dark_r <= activity_i;
         cnt_r <= '0;
      end else if (half_done_w) begin
         cnt_r <= '0;
         dark_r <= 1'b0;
         busy_r <= dark_r;
      end else begin
         cnt_r <= cnt_r + CW'(1);
      end
   end

   assign dark_o = dark_r;

   a_blink_full_half: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      ($fell(dark_r) && !$past(restart_i)) |-> ($past(cnt_r) == HALF_LAST))
      else $error("dark phase ended before a full half period");

endmodule : link_blink

// file: verification/mgmt_ctl_model.sv
// Station management controller model: clocks out whole management frames.
// Assumes the bench resolves the shared data wire, with a pull-up when nobody drives.
`timescale 1ns/100ps
module mgmt_ctl_model #(
   parameter int HALF = 5
) (
   input wire logic core_clk_i,
   input wire logic mdio_pin_i,
   output logic mdc_o,
   output logic mdio_o,
   output logic mdio_oe_o
);
   // Clock stands low and the line is released between frames
   initial begin
      mdc_o = 1'b0;
      mdio_o = 1'b1;
      mdio_oe_o = 1'b0;
   end

   // One bit slot: data changes while the clock is low, sampled at the rise
   task automatic slot(input logic drive, input logic val, output logic seen);
      mdc_o = 1'b0;
      mdio_oe_o = drive;
      mdio_o = val;
      repeat (HALF) @(negedge core_clk_i);
      seen = mdio_pin_i;
      mdc_o = 1'b1;
      repeat (HALF) @(negedge core_clk_i);
   endtask : slot

   // Whole frame; the line is released in turnaround and data of a read
   task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] phy,
                        input logic [4:0] regad, input logic [15:0] wdata,
                        output logic [15:0] rdata);
      logic [13:0] hdr;
      logic s;
      logic wr;
      hdr = {2'b01, op, phy, regad};
      wr = (op == phy_cfg_pkg::OP_WRITE);
      @(negedge core_clk_i);
      if (pre) begin
         for (int i = 0; i < int'(phy_cfg_pkg::PREAMBLE_BITS); i++) slot(1'b1, 1'b1, s);
      end
      for (int i = 13; i >= 0; i--) slot(1'b1, hdr[i], s);
      slot(wr, 1'b1, s);
      slot(wr, 1'b0, s);
      for (int i = 15; i >= 0; i--) begin
         slot(wr, wdata[i], s);
         rdata[i] = s;
      end
      mdc_o = 1'b0;
      mdio_oe_o = 1'b0;
      repeat (2 * HALF) @(negedge core_clk_i);
   endtask : frame
endmodule : mgmt_ctl_model

// file: verification/phy_vendor_config_low_bits_tb.sv
// Self-checking bench for the low configuration bits, driven over management frames.
// Assumes the controller model above and a pulled-up management data wire.
`timescale 1ns/100ps
module phy_vendor_config_low_bits_tb;
   localparam int BLINK = 8;
   localparam logic [4:0] PHY = 5'h05;
   localparam logic [4:0] REG = phy_cfg_pkg::REG_VENDOR_CONFIG;
   logic core_clk, arst_n, mdc, dut_mdio, dut_oe, mdl_mdio, mdl_oe, mdio_pin;
   phy_cfg_pkg::line_status_t line_status;
   logic [4:0] rx_sym, tx_sym, line_tx_sym;
   logic link_led, duplex_led, sm_reset, sleep;
   logic [15:0] rdata;
   int mismatches = 0;
   int samples_checked = 0;
   int cycles = 0;
   int sm_high = 0;

   // Wire resolution with pull-up
   assign mdio_pin = dut_oe ? dut_mdio : (mdl_oe ? mdl_mdio : 1'b1);

   phy_vendor_config_low_bits #(.BLINK_HALF_CYCLES(BLINK)) phy_vendor_config_low_bits_inst (
      .core_clk_i(core_clk), .arst_n_i(arst_n), .mdc_i(mdc), .mdio_i(mdio_pin),
      .mdio_o(dut_mdio), .mdio_oe_o(dut_oe), .phy_addr_i(PHY), .line_status_i(line_status),
      .rx_sym_i(rx_sym), .tx_sym_i(tx_sym), .line_tx_sym_o(line_tx_sym),
      .link_led_out_o(link_led), .duplex_led_out_o(duplex_led), .sm_reset_o(sm_reset),
      .sleep_o(sleep));

   mgmt_ctl_model mgmt_ctl_model_inst (
      .core_clk_i(core_clk), .mdio_pin_i(mdio_pin), .mdc_o(mdc), .mdio_o(mdl_mdio),
      .mdio_oe_o(mdl_oe));

   // Clock
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // Pulse length counter and hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (sm_reset === 1'b1) sm_high++;
      if (cycles == 40000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   task automatic step(input int n);
      repeat (n) @(negedge core_clk);
   endtask : step

   task automatic tally(input logic ok, input string what);
      samples_checked++;
      if (!ok) begin
         mismatches++;
         $display("ERROR t=%0t %s", $time, what);
      end
   endtask : tally

   task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
      tally(got === exp, $sformatf("register word %h, expected %h", got, exp));
   endtask : chk_reg

   task automatic chk_pin(input logic got, input logic exp, input string name);
      tally(got === exp, $sformatf("%s is %b, expected %b", name, got, exp));
   endtask : chk_pin

   task automatic chk_sym(input logic [4:0] got, input logic [4:0] exp);
      tally(got === exp, $sformatf("transmit symbol %h, expected %h", got, exp));
   endtask : chk_sym

   task automatic chk_count(input int got, input int exp);
      tally(got == exp, $sformatf("reset pulse %0d cycles, expected %0d", got, exp));
   endtask : chk_count

   task automatic wr(input logic [15:0] d, input logic pre = 1'b1);
      logic [15:0] r;
      mgmt_ctl_model_inst.frame(pre, phy_cfg_pkg::OP_WRITE, PHY, REG, d, r);
   endtask : wr

   task automatic rd(output logic [15:0] d, input logic [4:0] regad = REG,
                     input logic [4:0] phy = PHY, input logic pre = 1'b1);
      mgmt_ctl_model_inst.frame(pre, phy_cfg_pkg::OP_READ, phy, regad, 16'h0000, d);
   endtask : rd

   // Verdict and end of run
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish

   // Main sequence
   initial begin
      arst_n = 1'b0;
      line_status = '0;
      rx_sym = 5'h00;
      tx_sym = 5'h00;
      step(16);
      arst_n = 1'b1;
      step(8);
      // Reset state and register read-back
      chk_pin(sleep, 1'b0, "sleep");
      chk_pin(sm_reset, 1'b0, "machine reset");
      rd(rdata);
      chk_reg(rdata, phy_cfg_pkg::VENDOR_CONFIG_RESET);
      // Other register and other address stay silent
      rd(rdata, 5'h11);
      chk_reg(rdata, 16'hFFFF);
      rd(rdata, REG, 5'h06);
      chk_reg(rdata, 16'hFFFF);
      // Preamble required, then suppressed
      wr(16'h0001, 1'b0);
      rd(rdata);
      chk_reg(rdata, 16'h0000);
      wr(16'h0004);
      wr(16'h0005, 1'b0);
      rd(rdata, REG, PHY, 1'b0);
      chk_reg(rdata, 16'h0005);
      // Upper bits ignored; loopout chooses the transmit source
      wr(16'hFFC1);
      rd(rdata);
      chk_reg(rdata, 16'h0001);
      rx_sym = 5'h15;
      tx_sym = 5'h0A;
      step(2);
      chk_sym(line_tx_sym, 5'h15);
      wr(16'h0000);
      chk_sym(line_tx_sym, 5'h0A);
      // Link indicator, link only then with blink on traffic
      line_status.link_good = 1'b1;
      step(2);
      chk_pin(link_led, 1'b1, "link led");
      line_status.activity = 1'b1;
      step(1);
      line_status.activity = 1'b0;
      step(3);
      chk_pin(link_led, 1'b1, "link led");
      wr(16'h0020);
      chk_pin(link_led, 1'b1, "link led");
      line_status.activity = 1'b1;
      step(1);
      line_status.activity = 1'b0;
      step(3);
      chk_pin(link_led, 1'b0, "link led");
      step(10);
      chk_pin(link_led, 1'b1, "link led");
      line_status.link_good = 1'b0;
      step(2);
      chk_pin(link_led, 1'b0, "link led");
      // Duplex indicator in both modes over all status mixes
      for (int m = 0; m < 2; m++) begin
         wr(m ? 16'h0010 : 16'h0000);
         for (int s = 0; s < 8; s++) begin
            {line_status.full_duplex, line_status.speed_10, line_status.polarity_reversed} = 3'(s);
            step(2);
            chk_pin(duplex_led, m ? (s[1] & s[0]) : s[2], "duplex led");
         end
      end
      // Machine reset pulse clears itself, other bits kept
      sm_high = 0;
      wr(16'h0028);
      step(20);
      chk_count(sm_high, phy_cfg_pkg::SM_RESET_CYCLES);
      rd(rdata);
      chk_reg(rdata, 16'h0020);
      // Sleep, then wake with config kept and machines restarted
      line_status = '0;
      line_status.link_good = 1'b1;
      line_status.full_duplex = 1'b1;
      wr(16'h0022);
      chk_pin(sleep, 1'b1, "sleep");
      chk_pin(link_led, 1'b0, "link led");
      chk_pin(duplex_led, 1'b0, "duplex led");
      sm_high = 0;
      wr(16'h0020);
      step(20);
      chk_pin(sleep, 1'b0, "sleep");
      chk_count(sm_high, phy_cfg_pkg::SM_RESET_CYCLES);
      chk_pin(link_led, 1'b1, "link led");
      rd(rdata);
      chk_reg(rdata, 16'h0020);
      tally_and_finish();
   end
endmodule : phy_vendor_config_low_bits_tb
